//--- sfc_cfg.svh
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH
`define SFC_FRAME_BITS   32
`define SFC_CRC_BITS     5
`define SFC_LOOP_BITS    6
`define SFC_LOOP_INIT    6'h11
`define SFC_POLY         6'h25
`define SFC_CNT_BITS     6
`define SFC_CRC_ZERO     5'h00
`define SFC_RSP_STATUS_LSB 5
`define SFC_RSP_STATUS_MSB 20
`define SFC_RSP_COUNT_LSB  21
`define SFC_RSP_COUNT_MSB  24
`define SFC_RSP_FF_BIT     28
`define SFC_RSP_V_BIT      29
`define SFC_RSP_NAD_LSB    30
`endif

//--- sfc_pkg.sv
`default_nettype none
package sfc_pkg;
    typedef struct packed {
        logic [1:0]  node_address_field;
        logic [1:0]  command;
        logic [6:0]  reg_address;
        logic [15:0] data;
        logic [4:0]  crc;
    } sfc_host_frame_type;

    typedef struct packed {
        logic        serial_fault_flag;
        logic        general_fault_flag;
        logic        valid;
    } sfc_check_type;

    typedef enum logic [2:0] {
        SFC_IDLE = 3'b001,
        SFC_RUN  = 3'b010,
        SFC_DONE = 3'b100
    } sfc_state_type;
endpackage
`default_nettype wire

//--- sfc_crc5.sv
`include "sfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfc_crc5 #(
    parameter int FRAME_BITS = `SFC_FRAME_BITS
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        rx_valid_i,
    input  wire sfc_pkg::sfc_host_frame_type rx_frame_i,
    input  wire logic                        tx_valid_i,
    input  wire logic [FRAME_BITS-1:0]       tx_frame_i,
    output logic                             busy_o,
    output var sfc_pkg::sfc_check_type       check_o,
    output logic                             check_valid_o,
    output logic [FRAME_BITS-1:0]            tx_frame_o,
    output logic                             tx_done_o
);
    localparam int HDR_BITS = FRAME_BITS - `SFC_CRC_BITS;

    // the host frame struct fixes the width, so nothing else is served
    if (FRAME_BITS != `SFC_FRAME_BITS)
    begin : g_width_check
        $error("frame width must match the host frame");
    end

    // one loop step: shift in at stage zero, drop stage five, xor on top
    function automatic logic [`SFC_LOOP_BITS-1:0] crc_step(
        input logic [`SFC_LOOP_BITS-1:0] loop,
        input logic                      din
    );
        logic [`SFC_LOOP_BITS-1:0] s;
        s = {loop[`SFC_LOOP_BITS-2:0], din};
        if (s[`SFC_LOOP_BITS-1])
            s = s ^ `SFC_POLY;
        return s;
    endfunction

    // remainder held in the five low loop stages
    function automatic logic [`SFC_CRC_BITS-1:0] remainder_of(
        input logic [`SFC_LOOP_BITS-1:0] loop
    );
        return loop[`SFC_CRC_BITS-1:0];
    endfunction

    // control group
    sfc_pkg::sfc_state_type    state_q, state_d;
    logic [`SFC_CNT_BITS-1:0]  cnt_q, cnt_d;
    logic                      is_tx_q, is_tx_d;
    logic                      take_rx;
    logic                      take_tx;
    logic                      last_bit;
    // datapath group
    logic [`SFC_LOOP_BITS-1:0] loop_q, loop_d;
    logic [FRAME_BITS-1:0]     buf_q, buf_d;
    logic [HDR_BITS-1:0]       hdr_q, hdr_d;
    // result group
    sfc_pkg::sfc_check_type    chk_q, chk_d;
    logic                      chk_v_q, chk_v_d;
    logic [FRAME_BITS-1:0]     txo_q, txo_d;
    logic                      txd_q, txd_d;

    // a request is taken only while idle; rx wins over tx
    assign take_rx  = (state_q == sfc_pkg::SFC_IDLE) && rx_valid_i;
    assign take_tx  = (state_q == sfc_pkg::SFC_IDLE) && tx_valid_i
                      && !rx_valid_i;
    assign last_bit = (cnt_q == `SFC_CNT_BITS'(FRAME_BITS - 1));

    // counts the shift steps of one division
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        is_tx_d = is_tx_q;
        case (state_q)
            sfc_pkg::SFC_IDLE:
            begin
                cnt_d = '0;
                if (take_rx || take_tx)
                begin
                    is_tx_d = take_tx;
                    state_d = sfc_pkg::SFC_RUN;
                end
            end
            sfc_pkg::SFC_RUN:
            begin
                cnt_d = cnt_q + 1'b1;
                if (last_bit)
                    state_d = sfc_pkg::SFC_DONE;
            end
            sfc_pkg::SFC_DONE:
                state_d = sfc_pkg::SFC_IDLE;
            default:
                state_d = sfc_pkg::SFC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= sfc_pkg::SFC_IDLE;
            cnt_q   <= '0;
            is_tx_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            is_tx_q <= is_tx_d;
        end
    end

    // loop and frame buffer, one bit per cycle while running
    always_comb
    begin
        loop_d = loop_q;
        buf_d  = buf_q;
        hdr_d  = hdr_q;
        if (take_rx)
        begin
            buf_d  = rx_frame_i;
            loop_d = `SFC_LOOP_INIT;
        end
        else if (take_tx)
        begin
            // header kept so the host may change tx_frame_i while busy
            hdr_d  = tx_frame_i[FRAME_BITS-1:`SFC_CRC_BITS];
            buf_d  = {tx_frame_i[FRAME_BITS-1:`SFC_CRC_BITS],
                      `SFC_CRC_ZERO};
            loop_d = `SFC_LOOP_INIT;
        end
        else if (state_q == sfc_pkg::SFC_RUN)
        begin
            loop_d = crc_step(loop_q, buf_q[FRAME_BITS-1]);
            buf_d  = {buf_q[FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            loop_q <= `SFC_LOOP_INIT;
            buf_q  <= '0;
            hdr_q  <= '0;
        end
        else
        begin
            loop_q <= loop_d;
            buf_q  <= buf_d;
            hdr_q  <= hdr_d;
        end
    end

    // verdict and sealed frame are registered in the done cycle
    always_comb
    begin
        chk_d   = chk_q;
        chk_v_d = 1'b0;
        txo_d   = txo_q;
        txd_d   = 1'b0;
        if (state_q == sfc_pkg::SFC_DONE)
        begin
            if (is_tx_q)
            begin
                txo_d = {hdr_q, remainder_of(loop_q)};
                txd_d = 1'b1;
            end
            else
            begin
                chk_v_d = 1'b1;
                if (remainder_of(loop_q) != `SFC_CRC_ZERO)
                begin
                    chk_d.serial_fault_flag  = 1'b1;
                    chk_d.general_fault_flag = 1'b1;
                    chk_d.valid              = 1'b0;
                end
                else
                begin
                    chk_d.serial_fault_flag  = 1'b0;
                    chk_d.general_fault_flag = 1'b0;
                    chk_d.valid              = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            chk_q   <= '{serial_fault_flag: 1'b0, general_fault_flag: 1'b0,
                         valid: 1'b1};
            chk_v_q <= 1'b0;
            txo_q   <= '0;
            txd_q   <= 1'b0;
        end
        else
        begin
            chk_q   <= chk_d;
            chk_v_q <= chk_v_d;
            txo_q   <= txo_d;
            txd_q   <= txd_d;
        end
    end

    assign busy_o        = (state_q != sfc_pkg::SFC_IDLE);
    assign check_o       = chk_q;
    assign check_valid_o = chk_v_q;
    assign tx_frame_o    = txo_q;
    assign tx_done_o     = txd_q;
endmodule
`default_nettype wire

//--- sfc_crc5_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_crc5_asserts (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   rx_valid_i,
    input wire logic                   tx_valid_i,
    input wire logic                   busy_o,
    input wire sfc_pkg::sfc_check_type check_o,
    input wire logic                   check_valid_o,
    input wire logic                   tx_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence rx_take_s; !busy_o && rx_valid_i; endsequence
    sequence tx_take_s; !busy_o && tx_valid_i && !rx_valid_i; endsequence
    busy_start_a: assert property (
        !busy_o && (rx_valid_i || tx_valid_i) |=> busy_o) else $error("no busy");
    busy_span_a: assert property ($rose(busy_o) |->
        busy_o[*8] ##25 busy_o ##1 !busy_o) else $error("busy span wrong");
    rx_answer_a: assert property (rx_take_s |-> ##34 check_valid_o)
        else $error("check answer late");
    tx_answer_a: assert property (tx_take_s |-> ##34 tx_done_o)
        else $error("crc answer late");
    valid_pulse_a: assert property (check_valid_o |=> !check_valid_o)
        else $error("check pulse too long");
    done_pulse_a: assert property (tx_done_o |=> !tx_done_o)
        else $error("done pulse too long");
    check_hold_a: assert property (!check_valid_o |-> $stable(check_o))
        else $error("verdict changed without pulse");
    flag_pair_a: assert property (check_valid_o |->
        check_o.serial_fault_flag == check_o.general_fault_flag &&
        check_o.valid != check_o.serial_fault_flag) else $error("flags disagree");
endmodule
bind sfc_crc5 sfc_crc5_asserts u_asserts (.clk_i, .rst_i, .rx_valid_i,
    .tx_valid_i, .busy_o, .check_o, .check_valid_o, .tx_done_o);
`default_nettype wire

//--- sfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model;
    function automatic logic [4:0] crc(input logic [31:0] f);
        logic [5:0] r;
        r = 6'h11;
        for (int i = 31; i >= 0; i--)
        begin
            r = {r[4:0], f[i]};
            if (r[5]) r = r ^ 6'h25;
        end
        return r[4:0];
    endfunction
    function automatic logic [31:0] seal(input logic [26:0] h);
        return {h, crc({h, 5'h00})};
    endfunction
endmodule
`default_nettype wire

//--- serial_frame_crc5_check_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch t=%0t %h %h", $time, a, b); end end
module serial_frame_crc5_check_tb_top;
    logic                        clk_i = 1'b0;
    logic                        rst_i = 1'b1;
    logic                        rx_valid_i = 1'b0, tx_valid_i = 1'b0;
    sfc_pkg::sfc_host_frame_type rx_frame_i = '0;
    logic [31:0]                 tx_frame_i = '0, tx_frame_o;
    logic                        busy_o, check_valid_o, tx_done_o;
    sfc_pkg::sfc_check_type      check_o;
    int                          num_errors = 0, comparisons = 0;
    logic [26:0] hdr [3] = '{27'h0, 27'h7ff_ffff, {2'h1, 2'h0, 7'h0f, 16'h4618}};
    always #2.5 clk_i = ~clk_i;
    sfc_host_model u_host ();
    sfc_crc5 u_dut (.clk_i, .rst_i, .rx_valid_i, .rx_frame_i, .tx_valid_i,
        .tx_frame_i, .busy_o, .check_o, .check_valid_o, .tx_frame_o, .tx_done_o);
    task automatic run(input logic r, input logic [31:0] f, input logic ok);
        int n;
        rx_frame_i <= f;
        tx_frame_i <= f;
        rx_valid_i <= r;
        tx_valid_i <= !r;
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        tx_valid_i <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1 n++;
        end while ((r ? check_valid_o : tx_done_o) !== 1'b1 && n < 50);
        if (r) `CHK(check_o, {!ok, !ok, ok})
        else `CHK(tx_frame_o, u_host.seal(f[31:5]))
        `CHK(n, 33)
        @(posedge clk_i);
    endtask
    task automatic t_good();
        foreach (hdr[i]) run(1'b1, u_host.seal(hdr[i]), 1'b1);
        $display("t_good done");
    endtask
    task automatic t_bad();
        for (int i = 0; i < 32; i += 5)
            run(1'b1, u_host.seal(hdr[2]) ^ (32'h0000_0001 << i), 1'b0);
        $display("t_bad done");
    endtask
    task automatic t_tx();
        foreach (hdr[i]) run(1'b0, {hdr[i], 5'h1f}, 1'b1);
        $display("t_tx done");
    endtask
    task automatic t_reset();
        int n;
        tx_frame_i <= {hdr[2], 5'h00};
        tx_valid_i <= 1'b1;
        @(posedge clk_i);
        tx_valid_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 `CHK({busy_o, check_valid_o, tx_done_o}, 3'h0)
        `CHK(check_o, 3'h1)
        `CHK(tx_frame_o, 32'h0)
        @(posedge clk_i);
        rst_i <= 1'b0;
        rx_frame_i <= u_host.seal(hdr[1]);
        rx_valid_i <= 1'b1;
        tx_valid_i <= 1'b1;
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        tx_valid_i <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1 n++;
        end while ((check_valid_o | tx_done_o) !== 1'b1 && n < 50);
        `CHK({check_valid_o, tx_done_o}, 2'h2)
        `CHK(check_o, 3'h1)
        `CHK(n, 33)
        @(posedge clk_i);
        $display("t_reset done");
    endtask
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        `CHK(check_o, 3'b001)
        rst_i <= 1'b0;
        t_good();
        t_bad();
        t_tx();
        t_reset();
        summarize();
    end
    initial
    begin
        #20000;
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
